/* verilog/dual_uart_host_port.sv */
// How it works
// RULE1: Address lines pick register per transaction
// RULE2: Data bus driven only during reads
// RULE3: Read strobe fall fetches and drives byte
// RULE4: Host captures read byte at strobe rise
// RULE5: Write strobe fall opens internal write
// RULE6: Write byte stored at strobe rise
// RULE7: Channel 0 reached only with select low
// RULE8: Channel 1 reached only with select low
// RULE9: Channel 0 enable drives irq, output2 low
// RULE10: Channel 1 irq follows its own enable
// RULE11: Enables reset to zero, irq floating
// RULE12: Tx ready low while tx holding empty
// RULE13: Rx ready low while rx byte waits
// RULE14: Two independent register sets, one per channel
// RULE15: No select means strobes ignored
// RULE16: Host never selects both, address stable
module dual_uart_host_port (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  dual_uart_bus_if.device BUS,
  input wire logic [1:0][7:0] I_RX_BYTE,
  input wire logic [1:0] I_RX_VALID,
  output logic [1:0][7:0] O_TX_BYTE,
  output logic [1:0] O_TX_VALID,
  input wire logic [1:0] I_TX_ACK,
  input wire logic [1:0] I_IRQ_REQ
);
  // Decode of the two selects: bit 1 valid, bit 0 channel
  function automatic logic [1:0] chan_pick(input logic sel0_n,
                                           input logic sel1_n);
    logic [1:0] pick;
    pick = 2'h0;
    // Only exactly one select low gives a channel
    if (!sel0_n && sel1_n) begin
      pick = 2'h2;
    end else if (sel0_n && !sel1_n) begin
      pick = 2'h3;
    end
    return pick;
  endfunction : chan_pick

  // Stored registers of both channels
  dual_uart_pkg::byte_t regs [dual_uart_pkg::NUM_CHAN]
                             [dual_uart_pkg::NUM_REGS];
  dual_uart_pkg::byte_t next_regs [dual_uart_pkg::NUM_CHAN]
                                  [dual_uart_pkg::NUM_REGS];
  // Holding bytes and their full flags
  dual_uart_pkg::byte_t rx_hold [dual_uart_pkg::NUM_CHAN];
  dual_uart_pkg::byte_t next_rx_hold [dual_uart_pkg::NUM_CHAN];
  dual_uart_pkg::byte_t tx_hold [dual_uart_pkg::NUM_CHAN];
  dual_uart_pkg::byte_t next_tx_hold [dual_uart_pkg::NUM_CHAN];
  logic [1:0] rx_full;
  logic [1:0] next_rx_full;
  logic [1:0] tx_full;
  logic [1:0] next_tx_full;
  // Previous strobe levels for edge detection
  logic rd_prev;
  logic next_rd_prev;
  logic wr_prev;
  logic next_wr_prev;
  // Open read cycle
  logic rd_active;
  logic next_rd_active;
  logic rd_chan;
  logic next_rd_chan;
  dual_uart_pkg::reg_idx_t rd_addr;
  dual_uart_pkg::reg_idx_t next_rd_addr;
  dual_uart_pkg::byte_t rd_data;
  dual_uart_pkg::byte_t next_rd_data;
  // Open write cycle
  logic wr_active;
  logic next_wr_active;
  logic wr_chan;
  logic next_wr_chan;
  dual_uart_pkg::reg_idx_t wr_addr;
  dual_uart_pkg::reg_idx_t next_wr_addr;
  // Strobe edges and select decode
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  logic [1:0] pick;
  // Interrupt output enable per channel
  logic [1:0] irq_en;

  // Edge detection and channel decode
  always_comb begin
    rd_fall = rd_prev && !BUS.read_strobe_n;
    rd_rise = !rd_prev && BUS.read_strobe_n;
    wr_fall = wr_prev && !BUS.write_strobe_n;
    wr_rise = !wr_prev && BUS.write_strobe_n;
    // RULE7: channel 0 by select
    // RULE8: channel 1 by select
    pick = chan_pick(BUS.chan0_select_n, BUS.chan1_select_n);
  end

  // Next values of the bus cycle and register state
  always_comb begin
    next_regs = regs;
    next_rx_hold = rx_hold;
    next_tx_hold = tx_hold;
    next_rx_full = rx_full;
    next_tx_full = tx_full;
    next_rd_prev = BUS.read_strobe_n;
    next_wr_prev = BUS.write_strobe_n;
    next_rd_active = rd_active;
    next_rd_chan = rd_chan;
    next_rd_addr = rd_addr;
    next_rd_data = rd_data;
    next_wr_active = wr_active;
    next_wr_chan = wr_chan;
    next_wr_addr = wr_addr;
    // RULE3: read fall fetches byte
    // RULE15: ignored without select
    if (rd_fall && pick[1] && !rd_active) begin
      next_rd_active = 1'b1;
      next_rd_chan = pick[0];
      // RULE1: address picks register
      next_rd_addr = BUS.reg_addr;
      if (BUS.reg_addr == dual_uart_pkg::HOLD_OFS) begin
        next_rd_data = rx_hold[pick[0]];
      end else begin
        next_rd_data = regs[pick[0]][BUS.reg_addr];
      end
    end
    // Read ends at strobe rise; a holding register read consumes the rx byte
    if (rd_rise && rd_active) begin
      next_rd_active = 1'b0;
      if (rd_addr == dual_uart_pkg::HOLD_OFS) begin
        next_rx_full[rd_chan] = 1'b0;
      end
    end
    // RULE5: write fall opens cycle
    if (wr_fall && pick[1] && !wr_active) begin
      next_wr_active = 1'b1;
      next_wr_chan = pick[0];
      next_wr_addr = BUS.reg_addr;
    end
    // Transmit side takes the tx byte
    for (int c = 0; c < dual_uart_pkg::NUM_CHAN; c++) begin
      if (tx_full[c] && I_TX_ACK[c]) begin
        next_tx_full[c] = 1'b0;
      end
    end
    // RULE6: store at write rise
    if (wr_rise && wr_active) begin
      next_wr_active = 1'b0;
      // RULE14: per channel register set
      if (wr_addr == dual_uart_pkg::HOLD_OFS) begin
        next_tx_hold[wr_chan] = BUS.data;
        next_tx_full[wr_chan] = 1'b1;
      end else begin
        next_regs[wr_chan][wr_addr] = BUS.data;
      end
    end
    // New rx byte wins over a same-cycle read clear
    for (int c = 0; c < dual_uart_pkg::NUM_CHAN; c++) begin
      if (I_RX_VALID[c]) begin
        next_rx_hold[c] = I_RX_BYTE[c];
        next_rx_full[c] = 1'b1;
      end
    end
  end

  // Register all state
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      // RULE11: enables cleared at reset
      for (int c = 0; c < dual_uart_pkg::NUM_CHAN; c++) begin
        for (int r = 0; r < dual_uart_pkg::NUM_REGS; r++) begin
          regs[c][r] <= dual_uart_pkg::REG_RESET;
        end
        rx_hold[c] <= dual_uart_pkg::REG_RESET;
        tx_hold[c] <= dual_uart_pkg::REG_RESET;
      end
      rx_full <= 2'h0;
      tx_full <= 2'h0;
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
      rd_active <= 1'b0;
      rd_chan <= 1'b0;
      rd_addr <= 3'h0;
      rd_data <= dual_uart_pkg::REG_RESET;
      wr_active <= 1'b0;
      wr_chan <= 1'b0;
      wr_addr <= 3'h0;
    end else begin
      regs <= next_regs;
      rx_hold <= next_rx_hold;
      tx_hold <= next_tx_hold;
      rx_full <= next_rx_full;
      tx_full <= next_tx_full;
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
      rd_active <= next_rd_active;
      rd_chan <= next_rd_chan;
      rd_addr <= next_rd_addr;
      rd_data <= next_rd_data;
      wr_active <= next_wr_active;
      wr_chan <= next_wr_chan;
      wr_addr <= next_wr_addr;
    end
  end

  // RULE2: drive bus only in reads
  assign BUS.dev_dout = rd_data;
  assign BUS.dev_doe = rd_active;

  // Per-channel user side and enable bits
  for (genvar g = 0; g < dual_uart_pkg::NUM_CHAN; g++) begin : g_chan
    assign irq_en[g] = regs[g][dual_uart_pkg::MODEM_CTRL_OFS]
                           [dual_uart_pkg::IRQ_EN_BIT];
    assign O_TX_BYTE[g] = tx_hold[g];
    assign O_TX_VALID[g] = tx_full[g];
  end

  // RULE9: channel 0 irq and output2
  assign BUS.chan0_irq_out = I_IRQ_REQ[0];
  assign BUS.chan0_irq_oe = irq_en[0];
  assign BUS.chan0_gp_out2_n = !irq_en[0];
  // RULE10: channel 1 irq and output2
  assign BUS.chan1_irq_out = I_IRQ_REQ[1];
  assign BUS.chan1_irq_oe = irq_en[1];
  assign BUS.chan1_gp_out2_n = !irq_en[1];

  // RULE12: tx ready from holding
  assign BUS.chan0_tx_ready_n = tx_full[0];
  assign BUS.chan1_tx_ready_n = tx_full[1];
  // RULE13: rx ready from holding
  assign BUS.chan0_rx_ready_n = !rx_full[0];
  assign BUS.chan1_rx_ready_n = !rx_full[1];
endmodule : dual_uart_host_port

/* verilog/dual_uart_pkg.sv */
package dual_uart_pkg;
  // Byte carried on the shared host bus
  typedef logic [7:0] byte_t;
  // Register index within one channel
  typedef logic [2:0] reg_idx_t;

  // Number of channels and registers per channel
  localparam int NUM_CHAN = 2;
  localparam int NUM_REGS = 8;

  // Holding register offset: read gives rx byte, write loads tx byte
  localparam reg_idx_t HOLD_OFS = 3'h0;
  // Modem control register offset
  localparam reg_idx_t MODEM_CTRL_OFS = 3'h4;
  // Interrupt output enable bit inside modem control
  localparam int IRQ_EN_BIT = 3;

  // Reset value of every stored register
  localparam byte_t REG_RESET = 8'h00;
  // Level seen on the data wire when nobody drives it
  localparam byte_t BUS_IDLE = 8'hff;

  // Host clock period and strobe timing
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 40;
  // Strobe low time in cycles, rounded up, at least two
  localparam int STROBE_CYC_RAW = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYCLES = (STROBE_CYC_RAW < 2) ? 2 : STROBE_CYC_RAW;
  // Width of the host strobe counter
  localparam int STROBE_CNT_W = 4;
endpackage : dual_uart_pkg

/* verilog/dual_uart_bus_if.sv */
interface dual_uart_bus_if;
  // Register address and strobes from the host
  logic [2:0] reg_addr;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan0_select_n;
  logic chan1_select_n;
  // Data drivers of both parties and the resolved wire
  logic [7:0] host_dout;
  logic host_doe;
  logic [7:0] dev_dout;
  logic dev_doe;
  logic [7:0] data;
  // Per-channel outputs of the device
  logic chan0_irq_out;
  logic chan0_irq_oe;
  logic chan1_irq_out;
  logic chan1_irq_oe;
  logic chan0_gp_out2_n;
  logic chan1_gp_out2_n;
  logic chan0_tx_ready_n;
  logic chan0_rx_ready_n;
  logic chan1_tx_ready_n;
  logic chan1_rx_ready_n;

  // Wire level from the enables, device first
  assign data = dev_doe ? dev_dout :
                (host_doe ? host_dout : dual_uart_pkg::BUS_IDLE);

  // Documented device end
  modport device (
    input reg_addr, read_strobe_n, write_strobe_n,
    input chan0_select_n, chan1_select_n, data,
    output dev_dout, dev_doe,
    output chan0_irq_out, chan0_irq_oe, chan1_irq_out, chan1_irq_oe,
    output chan0_gp_out2_n, chan1_gp_out2_n,
    output chan0_tx_ready_n, chan0_rx_ready_n,
    output chan1_tx_ready_n, chan1_rx_ready_n
  );

  // Host processor end
  modport host (
    output reg_addr, read_strobe_n, write_strobe_n,
    output chan0_select_n, chan1_select_n, host_dout, host_doe,
    input data,
    input chan0_irq_out, chan0_irq_oe, chan1_irq_out, chan1_irq_oe,
    input chan0_gp_out2_n, chan1_gp_out2_n,
    input chan0_tx_ready_n, chan0_rx_ready_n,
    input chan1_tx_ready_n, chan1_rx_ready_n
  );
endinterface : dual_uart_bus_if

/* verilog/dual_uart_host_master.sv */
module dual_uart_host_master (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  dual_uart_bus_if.host BUS,
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire logic I_REQ_WRITE,
  input wire logic I_REQ_CHAN,
  input wire logic [2:0] I_REQ_ADDR,
  input wire logic [7:0] I_REQ_WDATA,
  output logic O_RSP_VALID,
  output logic [7:0] O_RSP_RDATA
);
  // Bus cycle phases
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} phase_e;
  phase_e phase;
  phase_e next_phase;
  // Strobe length counter
  logic [dual_uart_pkg::STROBE_CNT_W-1:0] cnt;
  logic [dual_uart_pkg::STROBE_CNT_W-1:0] next_cnt;
  // Latched request
  logic is_write;
  logic next_is_write;
  logic sel0_n;
  logic next_sel0_n;
  logic sel1_n;
  logic next_sel1_n;
  dual_uart_pkg::reg_idx_t addr;
  dual_uart_pkg::reg_idx_t next_addr;
  dual_uart_pkg::byte_t wdata;
  dual_uart_pkg::byte_t next_wdata;
  // Strobes and data enable
  logic rd_n;
  logic next_rd_n;
  logic wr_n;
  logic next_wr_n;
  logic doe;
  logic next_doe;
  // Answer
  logic rsp_valid;
  logic next_rsp_valid;
  dual_uart_pkg::byte_t rdata;
  dual_uart_pkg::byte_t next_rdata;

  // Phase sequencing
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_is_write = is_write;
    next_sel0_n = sel0_n;
    next_sel1_n = sel1_n;
    next_addr = addr;
    next_wdata = wdata;
    next_rd_n = rd_n;
    next_wr_n = wr_n;
    next_doe = doe;
    next_rsp_valid = 1'b0;
    next_rdata = rdata;
    case (phase)
      // Accept a request, one select only
      IDLE: begin
        if (I_REQ_VALID) begin
          next_phase = SETUP;
          next_is_write = I_REQ_WRITE;
          // RULE16: one select, address held
          next_sel0_n = I_REQ_CHAN;
          next_sel1_n = !I_REQ_CHAN;
          next_addr = I_REQ_ADDR;
          next_wdata = I_REQ_WDATA;
          next_doe = I_REQ_WRITE;
        end
      end
      // Address settled, open strobe
      SETUP: begin
        next_phase = STROBE;
        next_cnt = '0;
        next_rd_n = is_write;
        next_wr_n = !is_write;
      end
      // Strobe low for a fixed count
      STROBE: begin
        next_cnt = cnt + 1'b1;
        if (int'(cnt) == dual_uart_pkg::STROBE_CYCLES - 1) begin
          next_phase = HOLD;
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
        end
      end
      // Address and data held past the rise; read byte taken
      HOLD: begin
        next_phase = IDLE;
        next_sel0_n = 1'b1;
        next_sel1_n = 1'b1;
        next_doe = 1'b0;
        next_rsp_valid = 1'b1;
        // RULE4: byte taken after rise
        if (!is_write) begin
          next_rdata = BUS.data;
        end
      end
      default: begin
        next_phase = IDLE;
      end
    endcase
  end

  // Register host state
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      phase <= IDLE;
      cnt <= '0;
      is_write <= 1'b0;
      sel0_n <= 1'b1;
      sel1_n <= 1'b1;
      addr <= 3'h0;
      wdata <= dual_uart_pkg::REG_RESET;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      doe <= 1'b0;
      rsp_valid <= 1'b0;
      rdata <= dual_uart_pkg::REG_RESET;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      is_write <= next_is_write;
      sel0_n <= next_sel0_n;
      sel1_n <= next_sel1_n;
      addr <= next_addr;
      wdata <= next_wdata;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      doe <= next_doe;
      rsp_valid <= next_rsp_valid;
      rdata <= next_rdata;
    end
  end

  // Pins and user answer
  assign BUS.reg_addr = addr;
  assign BUS.chan0_select_n = sel0_n;
  assign BUS.chan1_select_n = sel1_n;
  assign BUS.read_strobe_n = rd_n;
  assign BUS.write_strobe_n = wr_n;
  assign BUS.host_dout = wdata;
  assign BUS.host_doe = doe;
  assign O_REQ_READY = (phase == IDLE);
  assign O_RSP_VALID = rsp_valid;
  assign O_RSP_RDATA = rdata;
endmodule : dual_uart_host_master

/* verification/dual_uart_bus_properties.sv */
module dual_uart_bus_checker (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic [2:0] reg_addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan0_select_n,
  input wire logic chan1_select_n,
  input wire logic [7:0] dev_dout,
  input wire logic dev_doe,
  input wire logic chan0_irq_oe,
  input wire logic chan1_irq_oe,
  input wire logic chan0_gp_out2_n,
  input wire logic chan1_gp_out2_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single clock domain
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  a_read_drive_start: assert property (
    $fell(read_strobe_n) && (chan0_select_n != chan1_select_n)
    |=> dev_doe) else $error("read strobe did not drive bus");
  a_read_release: assert property (
    $rose(read_strobe_n) |=> !dev_doe) else $error("bus held after read");
  a_write_no_drive: assert property (
    !write_strobe_n |-> !dev_doe) else $error("bus driven during write");
  a_idle_quiet: assert property (
    chan0_select_n && chan1_select_n
    && $past(chan0_select_n && chan1_select_n) |-> !dev_doe)
    else $error("bus driven with no select");
  a_read_data_hold: assert property (
    dev_doe && $past(dev_doe) |-> $stable(dev_dout))
    else $error("read byte changed while driven");
  a_chan0_out2: assert property (
    chan0_gp_out2_n == !chan0_irq_oe) else $error("chan0 output2 wrong");
  a_chan1_out2: assert property (
    chan1_gp_out2_n == !chan1_irq_oe) else $error("chan1 output2 wrong");
  a_enable_reset: assert property (
    $rose(I_RSTN) |-> !chan0_irq_oe && !chan1_irq_oe)
    else $error("irq enable set after reset");
  a_enable_by_sel: assert property (
    $rose(chan0_irq_oe) |-> !$past(chan0_select_n)
    && $past(reg_addr) == 3'h4) else $error("chan0 enable set wrongly");
endmodule : dual_uart_bus_checker

/* verification/dual_uart_host_bus_port_tb.sv */
module dual_uart_host_bus_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn;
  logic [1:0][7:0] rx_byte;
  logic [1:0] rx_valid;
  logic [1:0][7:0] tx_byte;
  logic [1:0] tx_valid;
  logic [1:0] tx_ack;
  logic [1:0] irq_req;
  logic req_valid, req_ready, req_write, req_chan, rsp_valid;
  logic [2:0] req_addr;
  logic [7:0] req_wdata, rsp_rdata, wd, rd;
  logic [7:0] shadow [2][8];
  int err_total, tests_run, k, c, a;

  dual_uart_bus_if link ();
  dual_uart_host_port i_dual_uart_host_port (.I_CLOCK(clock),
    .I_RSTN(rstn), .BUS(link), .I_RX_BYTE(rx_byte), .I_RX_VALID(rx_valid),
    .O_TX_BYTE(tx_byte), .O_TX_VALID(tx_valid), .I_TX_ACK(tx_ack),
    .I_IRQ_REQ(irq_req));
  dual_uart_host_master i_dual_uart_host_master (.I_CLOCK(clock),
    .I_RSTN(rstn), .BUS(link), .I_REQ_VALID(req_valid),
    .O_REQ_READY(req_ready), .I_REQ_WRITE(req_write), .I_REQ_CHAN(req_chan),
    .I_REQ_ADDR(req_addr), .I_REQ_WDATA(req_wdata),
    .O_RSP_VALID(rsp_valid), .O_RSP_RDATA(rsp_rdata));
  dual_uart_bus_checker i_dual_uart_bus_checker (.I_CLOCK(clock),
    .I_RSTN(rstn), .reg_addr(link.reg_addr),
    .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
    .chan0_select_n(link.chan0_select_n), .chan1_select_n(link.chan1_select_n),
    .dev_dout(link.dev_dout), .dev_doe(link.dev_doe),
    .chan0_irq_oe(link.chan0_irq_oe), .chan1_irq_oe(link.chan1_irq_oe),
    .chan0_gp_out2_n(link.chan0_gp_out2_n),
    .chan1_gp_out2_n(link.chan1_gp_out2_n));

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Counts, verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // One comparison, four-state exact
  task check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Cut a hang short
  task guard(input int n);
    if (n > 40) begin
      err_total++;
      $display("FAIL wait expected done seen timeout");
      finish_test();
    end
  endtask : guard

  // One host request through the master, waits for its response
  task xfer(input logic wr, input logic ch, input logic [2:0] ad,
            input logic [7:0] dat, output logic [7:0] rdv);
    int n;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1) begin
      n++;
      guard(n);
      @(negedge clock);
    end
    req_write = wr;
    req_chan = ch;
    req_addr = ad;
    req_wdata = dat;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      n++;
      guard(n);
      @(negedge clock);
    end
    rdv = rsp_rdata;
  endtask : xfer

  // Expected irq enable from a modem control byte
  function automatic logic irq_en(input logic [7:0] v);
    return v[dual_uart_pkg::IRQ_EN_BIT];
  endfunction : irq_en

  // Main sequence
  initial begin
    rstn = 1'b0;
    {req_valid, req_write, req_chan, req_addr, req_wdata} = '0;
    {rx_byte, rx_valid, tx_ack, irq_req} = '0;
    err_total = 0;
    tests_run = 0;
    for (k = 0; k < 16; k++) begin
      shadow[k / 8][k % 8] = dual_uart_pkg::REG_RESET;
    end
    void'($urandom(71993));
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    // Status pins after reset
    check("reset pins", 8'h33, {link.chan0_tx_ready_n, link.chan1_tx_ready_n,
      link.chan0_rx_ready_n, link.chan1_rx_ready_n, link.chan0_irq_oe,
      link.chan1_irq_oe, link.chan0_gp_out2_n, link.chan1_gp_out2_n});
    check("idle wire", dual_uart_pkg::BUS_IDLE, link.data);
    // Random storage traffic, both channels kept apart
    for (k = 0; k < 60; k++) begin
      c = $urandom_range(1, 0);
      a = $urandom_range(7, 1);
      a = (a == 4) ? 5 : a;
      wd = 8'($urandom);
      if ($urandom_range(1, 0) == 1) begin
        xfer(1'b1, c[0], a[2:0], wd, rd);
        shadow[c][a] = wd;
      end else begin
        xfer(1'b0, c[0], a[2:0], wd, rd);
        check("stored byte", shadow[c][a], rd);
      end
    end
    // Irq enable per channel, table of on and off cases
    for (k = 0; k < 5; k++) begin
      c = k % 2;
      irq_req = 2'($urandom);
      wd = (8'($urandom) & 8'hf7) | {4'h0, k[1], 3'h0};
      xfer(1'b1, c[0], dual_uart_pkg::MODEM_CTRL_OFS, wd, rd);
      shadow[c][4] = wd;
      @(negedge clock);
      check("irq enable", {4'h0, irq_en(shadow[0][4]), !irq_en(shadow[0][4]),
        irq_en(shadow[1][4]), !irq_en(shadow[1][4])}, {4'h0,
        link.chan0_irq_oe, link.chan0_gp_out2_n, link.chan1_irq_oe,
        link.chan1_gp_out2_n});
      check("irq level", {6'h00, irq_req},
        {6'h00, link.chan1_irq_out, link.chan0_irq_out});
      xfer(1'b0, c[0], dual_uart_pkg::MODEM_CTRL_OFS, 8'h00, rd);
      check("modem ctrl", wd, rd);
    end
    // Transmit holding of the second channel
    wd = 8'($urandom);
    xfer(1'b1, 1'b1, dual_uart_pkg::HOLD_OFS, wd, rd);
    repeat (2) @(negedge clock);
    check("tx full", 8'h0a, {4'h0, tx_valid, link.chan1_tx_ready_n,
      link.chan0_tx_ready_n});
    check("tx byte", wd, tx_byte[1]);
    tx_ack = 2'b10;
    @(negedge clock);
    tx_ack = 2'b00;
    repeat (2) @(negedge clock);
    check("tx empty", 8'h00, {5'h00, tx_valid, link.chan1_tx_ready_n});
    // Receive holding of the first channel
    rx_byte[0] = 8'($urandom);
    rx_valid = 2'b01;
    @(negedge clock);
    rx_valid = 2'b00;
    repeat (2) @(negedge clock);
    check("rx full", 8'h02, {6'h00, link.chan1_rx_ready_n,
      link.chan0_rx_ready_n});
    xfer(1'b0, 1'b0, dual_uart_pkg::HOLD_OFS, 8'h00, rd);
    check("rx byte", rx_byte[0], rd);
    repeat (2) @(negedge clock);
    check("rx empty", 8'h03, {6'h00, link.chan1_rx_ready_n,
      link.chan0_rx_ready_n});
    check("idle wire", dual_uart_pkg::BUS_IDLE, link.data);
    finish_test();
  end
endmodule : dual_uart_host_bus_port_tb
